//--- cpc_pkg.sv
// Package of constants and types for the configuration pin control block.
// Contract
// - User pins float, pulled up, during configuration.
// - Unused pins float, pulled up, after configuration.
// - Reset input during configuration restarts loading.
// - After configuration reset is user or global.
// - Master and async peripheral drive config clock.
// - Microprocessor mode drives config clock for chaining.
// - Low completion pin delays start-up.
// - Completion pin is open-drain, high when done.
// - Program low restarts configuration, resets scan.
// - Trigger low during configuration tri-states all pins; the code ignores it in ST_INIT.
// - Option keeps trigger tri-stating after configuration.
// - Trigger falling edge starts readback at frame zero.
// - Shared pin carries readback data or test output.
// - Mode pins latched on rising init status.
// - Mode pins become user pins after configuration.
`default_nettype none
package cpc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_USED = 8'h0C;
   localparam int CTRL_LOAD_DONE = 0;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES = (INIT_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int CONFIG_CLOCK_PIN_HALF_NS = 60;
   localparam int CONFIG_CLOCK_PIN_HALF_CYCLES = (CONFIG_CLOCK_PIN_HALF_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [2:0] MODE_MASTER = 3'h0;
   localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
   localparam logic [2:0] MODE_MICRO = 3'h2;
   localparam logic [2:0] MODE_RESET = 3'h0;
   typedef enum logic [4:0] {
      ST_RESTART = 5'b00001,
      ST_INIT = 5'b00010,
      ST_CONFIG = 5'b00100,
      ST_STARTUP = 5'b01000,
      ST_USER = 5'b10000
   } cpc_state_type;
   typedef struct packed {
      logic scan_en;
      logic reset_direct;
      logic ts_after_cfg;
      logic readback_en;
   } cpc_ctrl_type;
endpackage : cpc_pkg
`default_nettype wire

//--- cpc_top.sv
// Configuration pin control: restart, clock direction, start-up, readback.
//
// Our own choices: the register addresses and the APB register port.
`default_nettype none
module cpc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '1;
         q <= '1;
      end else begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule : cpc_sync

////////////////////////////////////////////////////////////////////////////
module cpc_top #(
   parameter int USER_PINS = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic program_restart_n,
   input wire logic reset_pin_in,
   input wire logic config_clock_pin_in,
   output logic config_clock_pin_out,
   output logic config_clock_pin_oe,
   input wire logic done_pin_in,
   output logic done_pin_out,
   output logic done_pin_oe,
   input wire logic readback_trigger_n,
   input wire logic [2:0] mode_select_pins,
   output logic init_status,
   output logic readback_tdo_pin,
   input wire logic tdo_in,
   input wire logic [31:0] function_unit_state,
   input wire logic [USER_PINS-1:0] user_oe_req,
   output logic [USER_PINS-1:0] user_oe,
   output logic [USER_PINS-1:0] user_pullup,
   output logic reset_pullup,
   output logic mode_pullup,
   output logic mode_pins_user,
   output logic global_tristate,
   output logic global_set_reset,
   output logic user_reset,
   output logic scan_reset,
   output logic config_active
);
   import cpc_pkg::*;

   localparam int AW = $clog2(DEPTH);

   if (USER_PINS < 1 || USER_PINS > 32 || DEPTH < 2) begin : g_chk
      $error("cpc_top: USER_PINS must be 1..32 and DEPTH at least 2.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Every pin input is resynchronised before any decision looks at it.
   logic [7:0] pin_s;
   cpc_sync #(.W(8)) u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .d({program_restart_n, reset_pin_in, readback_trigger_n,
          done_pin_in, config_clock_pin_in, mode_select_pins}),
      .q(pin_s)
   );
   wire prog_s = pin_s[7];
   wire rst_s = pin_s[6];
   wire trig_s = pin_s[5];
   wire done_s = pin_s[4];
   wire config_clock_pin_s = pin_s[3];
   wire [2:0] mode_s = pin_s[2:0];

   cpc_state_type state;
   cpc_ctrl_type ctrl;
   logic [2:0] mode;
   logic [USER_PINS-1:0] used;
   logic [31:0] mem [DEPTH];
   logic [AW-1:0] wr_addr;
   logic [15:0] init_cnt;
   logic [7:0] div_cnt;
   logic config_clock_pin_q;
   logic config_clock_pin_d;
   logic trig_d;
   logic load_done;
   logic rb_active;
   logic rb_last;
   logic [AW-1:0] rb_addr;
   logic [4:0] rb_bit;
   logic [31:0] rb_shift;

   ////////////////////////////////////////////////////////////////////////
   wire is_user = (state == ST_USER);
   wire restart_req = !prog_s || (!rst_s && !is_user);
   wire init_end = (state == ST_INIT) && (init_cnt == 16'(INIT_CYCLES - 1));
   wire drive_mode = (mode == MODE_MASTER) || (mode == MODE_ASYNC_PERIPH)
                     || (mode == MODE_MICRO);
   wire div_wrap = (div_cnt == 8'(CONFIG_CLOCK_PIN_HALF_CYCLES - 1));
   // In slave modes the host's clock edges pace the logic instead.
   wire config_clock_pin_tick = drive_mode ? (div_wrap && !config_clock_pin_q)
                               : (config_clock_pin_s && !config_clock_pin_d);
   wire trig_fall = trig_d && !trig_s;
   wire rb_start = is_user && ctrl.readback_en && !ctrl.ts_after_cfg
                   && trig_fall && !rb_active;
   wire gts_now = !trig_s && (is_user ? ctrl.ts_after_cfg
                   : (state != ST_INIT));

   ////////////////////////////////////////////////////////////////////////
   // APB slave; the answer comes in the second access cycle.
   wire apb_acc = psel && penable && !pready;
   wire hit_ctrl = (paddr == OFF_CTRL);
   wire hit_status = (paddr == OFF_STATUS);
   wire hit_data = (paddr == OFF_DATA);
   wire hit_used = (paddr == OFF_USED);
   wire hit_any = hit_ctrl || hit_status || hit_data || hit_used;
   wire wr_ctrl = apb_acc && pwrite && hit_ctrl;
   wire wr_data = apb_acc && pwrite && hit_data && (state == ST_CONFIG)
                  && (wr_addr != AW'(DEPTH - 1));
   wire [2:0] wr_addr_pad = 3'(wr_addr);
   wire [31:0] status_word = {15'h0000, rb_active, init_status,
                              done_s, mode, 3'h0, state, wr_addr_pad};
   wire [31:0] used_word = 32'(used);
   wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl, 1'b0} :
                        hit_status ? status_word :
                        hit_used ? used_word : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_acc;
         pslverr <= apb_acc && !hit_any;
         prdata <= (apb_acc && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RESET;
         used <= '0;
         load_done <= 1'b0;
      end else begin
         load_done <= wr_ctrl && pwdata[CTRL_LOAD_DONE]
                      && (state == ST_CONFIG);
         if (wr_ctrl) begin
            ctrl <= pwdata[4:1];
         end
         if (apb_acc && pwrite && hit_used) begin
            used <= pwdata[USER_PINS-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_data) begin
         mem[wr_addr] <= pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: restart, initialisation, loading, start-up, user.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_RESTART;
         init_cnt <= 16'h0000;
         init_status <= 1'b0;
         mode <= MODE_RESET;
         wr_addr <= '0;
      end else if (restart_req) begin
         state <= ST_RESTART;
         init_cnt <= 16'h0000;
         init_status <= 1'b0;
         wr_addr <= '0;
      end else begin
         case (state)
            ST_RESTART: state <= ST_INIT;
            ST_INIT: begin
               init_cnt <= init_cnt + 16'h0001;
               if (init_end) begin
                  state <= ST_CONFIG;
                  init_status <= 1'b1;
                  mode <= mode_s;
               end
            end
            ST_CONFIG: begin
               if (wr_data) begin
                  wr_addr <= wr_addr + AW'(1);
               end
               if (load_done) begin
                  state <= ST_STARTUP;
               end
            end
            ST_STARTUP: begin
               if (done_s) begin
                  state <= ST_USER;
               end
            end
            ST_USER: state <= ST_USER;
            default: state <= ST_RESTART;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration clock divider and edge finder.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 8'h00;
         config_clock_pin_q <= 1'b0;
         config_clock_pin_d <= 1'b1;
         trig_d <= 1'b1;
      end else begin
         config_clock_pin_d <= config_clock_pin_s;
         trig_d <= trig_s;
         div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
         if (div_wrap) begin
            config_clock_pin_q <= !config_clock_pin_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readback walks the frames from zero, then the function unit states.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rb_active <= 1'b0;
         rb_last <= 1'b0;
         rb_addr <= '0;
         rb_bit <= 5'h00;
         rb_shift <= 32'h0000_0000;
      end else if (!is_user) begin
         rb_active <= 1'b0;
      end else if (rb_start) begin
         rb_active <= 1'b1;
         rb_last <= 1'b0;
         rb_addr <= '0;
         rb_bit <= 5'h00;
         rb_shift <= mem[0];
      end else if (rb_active && config_clock_pin_tick) begin
         rb_bit <= rb_bit + 5'h01;
         rb_shift <= {rb_shift[30:0], 1'b0};
         if (rb_bit == 5'h1F) begin
            rb_addr <= rb_addr + AW'(1);
            rb_last <= (rb_addr == AW'(DEPTH - 1));
            rb_active <= !rb_last;
            rb_shift <= (rb_addr == AW'(DEPTH - 1)) ? function_unit_state
                        : mem[rb_addr + AW'(1)];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, all registered.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         config_clock_pin_out <= 1'b0;
         config_clock_pin_oe <= 1'b0;
         done_pin_out <= 1'b0;
         done_pin_oe <= 1'b1;
         readback_tdo_pin <= 1'b1;
         user_oe <= '0;
         user_pullup <= '1;
         reset_pullup <= 1'b1;
         mode_pullup <= 1'b1;
         mode_pins_user <= 1'b0;
         global_tristate <= 1'b0;
         global_set_reset <= 1'b0;
         user_reset <= 1'b1;
         scan_reset <= 1'b1;
         config_active <= 1'b1;
      end else begin
         config_clock_pin_out <= config_clock_pin_q;
         config_clock_pin_oe <= drive_mode
                                && (!is_user || rb_active);
         done_pin_out <= 1'b0;
         // Open drain: the pin is pulled low until loading has finished.
         done_pin_oe <= (state != ST_STARTUP) && !is_user;
         readback_tdo_pin <= ctrl.scan_en ? tdo_in : rb_shift[31];
         user_oe <= (is_user && !gts_now) ? (user_oe_req & used)
                    : '0;
         user_pullup <= is_user ? ~used : '1;
         reset_pullup <= !is_user;
         mode_pullup <= !is_user;
         mode_pins_user <= is_user;
         global_tristate <= gts_now;
         // The synchroniser adds two cycles before the global reset acts.
         global_set_reset <= is_user && ctrl.reset_direct && !rst_s;
         user_reset <= (is_user && !ctrl.reset_direct) ? rst_s : 1'b1;
         scan_reset <= !prog_s;
         config_active <= !is_user;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   pin_float_cfg_a: assert property (!is_user
      |=> user_oe == '0 && user_pullup == '1)
      else $error("User pins driven during configuration.");
   unused_pullup_a: assert property (is_user
      |=> user_pullup == ~$past(used))
      else $error("Unused pin pull-up wrong after configuration.");
   reset_restart_a: assert property (!rst_s && !is_user
      && prog_s |=> state == ST_RESTART)
      else $error("Reset input did not restart configuration.");
   direct_reset_a: assert property (is_user && ctrl.reset_direct
      && !rst_s |=> global_set_reset)
      else $error("Direct reset did not reach the logic cells.");
   clk_drive_a: assert property (drive_mode && !is_user
      |=> config_clock_pin_oe)
      else $error("Config clock not driven in a driving mode.");
   clk_input_a: assert property (!drive_mode
      |=> !config_clock_pin_oe)
      else $error("Config clock driven in a slave mode.");
   startup_hold_a: assert property (state == ST_STARTUP
      && !done_s && !restart_req |=> state == ST_STARTUP)
      else $error("Start-up left while completion pin low.");
   done_pin_a: assert property (!done_pin_out
      && (done_pin_oe == $past(state != ST_STARTUP && !is_user)))
      else $error("Completion pin not open-drain as expected.");
   program_restart_a: assert property (!prog_s
      |=> state == ST_RESTART && scan_reset)
      else $error("Program input did not restart and reset scan.");
   tristate_cfg_a: assert property (!trig_s && state == ST_CONFIG
      |=> global_tristate ##1 user_oe == '0)
      else $error("Trigger low did not tri-state during configuration.");
   tristate_user_a: assert property (is_user && !ctrl.ts_after_cfg
      |=> !global_tristate)
      else $error("Tri-state active after configuration without option.");
   readback_start_a: assert property (rb_start
      |=> rb_active && rb_addr == '0 && rb_bit == 5'h00)
      else $error("Readback did not start at frame zero.");
   shared_pin_a: assert property (ctrl.scan_en
      |=> readback_tdo_pin == $past(tdo_in))
      else $error("Shared pin not carrying test data out.");
   mode_latch_a: assert property (!init_status && !restart_req
      && state == ST_INIT ##1 !init_status |-> $stable(mode))
      else $error("Mode changed away from the init rising edge.");
   mode_release_a: assert property (is_user
      |=> mode_pins_user && !mode_pullup)
      else $error("Mode pins not released after configuration.");

   full_config_c: cover property (state == ST_STARTUP ##[1:50] is_user);
   readback_c: cover property (rb_start ##[1:300] rb_bit == 5'h07);
   restart_c: cover property (state == ST_CONFIG ##1 state == ST_RESTART);
endmodule : cpc_top
`default_nettype wire

//--- cpc_host.sv
// Model of the configuration host and board logic around the pin block.
`default_nettype none
module cpc_host (
   input wire logic config_clock_pin_out,
   input wire logic config_clock_pin_oe,
   input wire logic done_pin_out,
   input wire logic done_pin_oe,
   input wire logic init_status,
   input wire logic run_clk,
   input wire logic hold_done,
   input wire logic trig_req_n,
   output logic config_clock_pin_in,
   output logic done_pin_in,
   output logic readback_trigger_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic host_clk = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // The host clock stands still low unless run_clk is high.
   always begin
      #62.5;
      host_clk = run_clk ? ~host_clk : 1'b0;
   end
   assign config_clock_pin_in = config_clock_pin_oe ? config_clock_pin_out
                                                    : host_clk;
   // Open drain with a board pull-up; either party may pull it low.
   assign done_pin_in = ~((done_pin_oe & ~done_pin_out) | hold_done);
   // The trigger is kept high until initialization has ended.
   assign readback_trigger_n = init_status ? trig_req_n : 1'b1;
endmodule : cpc_host
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the configuration pin control block.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cpc_pkg::*;
   logic clk_sys = 1'b0, arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic program_restart_n = 1'b1, reset_pin_in = 1'b1;
   logic cc_in, cc_out, cc_oe, done_in, done_out, done_oe, trig_n;
   logic run_clk = 1'b0, hold_done = 1'b0, trig_req_n = 1'b1;
   logic [2:0] mode = 3'h0;
   logic init_status, rb_pin, tdo_in = 1'b0;
   logic [31:0] fu_state = 32'h0F0F_1234;
   logic [7:0] user_oe_req = 8'hFF, user_oe, user_pullup;
   logic reset_pullup, mode_pullup, mode_pins_user, global_tristate;
   logic global_set_reset, user_reset, scan_reset, config_active;
   logic [7:0] got;
   int n_fail = 0, samples_checked = 0;
   logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
   logic drives [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   ////////////////////////////////////////////////////////////////////////
   always #2 clk_sys = ~clk_sys;
   cpc_top #(.USER_PINS(8), .DEPTH(16)) dut (.clk_sys(clk_sys),
      .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .program_restart_n(program_restart_n),
      .reset_pin_in(reset_pin_in), .config_clock_pin_in(cc_in),
      .config_clock_pin_out(cc_out), .config_clock_pin_oe(cc_oe),
      .done_pin_in(done_in), .done_pin_out(done_out),
      .done_pin_oe(done_oe), .readback_trigger_n(trig_n),
      .mode_select_pins(mode), .init_status(init_status),
      .readback_tdo_pin(rb_pin), .tdo_in(tdo_in),
      .function_unit_state(fu_state), .user_oe_req(user_oe_req),
      .user_oe(user_oe), .user_pullup(user_pullup),
      .reset_pullup(reset_pullup), .mode_pullup(mode_pullup),
      .mode_pins_user(mode_pins_user), .global_tristate(global_tristate),
      .global_set_reset(global_set_reset), .user_reset(user_reset),
      .scan_reset(scan_reset), .config_active(config_active));
   cpc_host host (.config_clock_pin_out(cc_out), .config_clock_pin_oe(cc_oe),
      .done_pin_out(done_out), .done_pin_oe(done_oe),
      .init_status(init_status), .run_clk(run_clk), .hold_done(hold_done),
      .trig_req_n(trig_req_n), .config_clock_pin_in(cc_in),
      .done_pin_in(done_in), .readback_trigger_n(trig_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // The request is held until pready is sampled high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("pready", 32'h0, 32'h1);
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // A which of 0 watches init_status, 1 watches config_active.
   task automatic wait_on(input bit which, input logic v, input int lim);
      int n;
      n = 0;
      while ((which ? config_active : init_status) !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= lim) begin
         chk("wait", 32'h0, 32'h1);
         conclude();
      end
   endtask : wait_on
   // Returns just after the config clock output has been seen rising.
   task automatic wait_tick;
      logic prev;
      prev = cc_out;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk_sys);
         if (prev === 1'b0 && cc_out === 1'b1) return;
         prev = cc_out;
      end
      chk("tick", 32'h0, 32'h1);
      conclude();
   endtask : wait_tick
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(10);
      chk("oe_rst", user_oe, 32'h0);
      chk("pu_rst", user_pullup, 32'hFF);
      arst_n <= 1'b1;
      foreach (modes[i]) begin
         mode <= modes[i];
         run_clk <= !drives[i];
         program_restart_n <= 1'b0;
         cyc(6);
         chk("scan_rst", scan_reset, 32'h1);
         chk("init_lo", init_status, 32'h0);
         program_restart_n <= 1'b1;
         cyc(1);
         wait_on(1'b0, 1'b1, 400);
         cyc(3);
         chk("config_clock_pin_oe", cc_oe, drives[i]);
         apb(1'b0, OFF_STATUS, 32'h0);
         chk("mode", rd[13:11], modes[i]);
         chk("state", rd[7:3], 32'h04);
      end
      reset_pin_in <= 1'b0;
      cyc(6);
      chk("rst_cfg", init_status, 32'h0);
      chk("rst_pu", reset_pullup, 32'h1);
      reset_pin_in <= 1'b1;
      cyc(1);
      wait_on(1'b0, 1'b1, 400);
      chk("oe_cfg", user_oe, 32'h0);
      chk("done_cfg", {done_oe, done_out}, 32'h2);
      chk("pu_cfg", user_pullup, 32'hFF);
      trig_req_n <= 1'b0;
      cyc(6);
      chk("ts_cfg", global_tristate, 32'h1);
      trig_req_n <= 1'b1;
      cyc(6);
      apb(1'b1, OFF_DATA, 32'hA5C3_0F96);
      apb(1'b1, OFF_DATA, 32'h1234_5678);
      apb(1'b1, OFF_USED, 32'h0F);
      apb(1'b0, OFF_USED, 32'h0);
      chk("used", rd, 32'h0F);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      hold_done <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h3);
      cyc(20);
      chk("done_oe", done_oe, 32'h0);
      chk("done_out", done_out, 32'h0);
      chk("held", config_active, 32'h1);
      hold_done <= 1'b0;
      cyc(1);
      wait_on(1'b1, 1'b0, 20);
      chk("mode_user", {mode_pins_user, mode_pullup}, 32'h2);
      chk("oe_used", user_oe, 32'h0F);
      chk("pu_used", user_pullup, 32'hF0);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("ctrl", rd, 32'h2);
      wait_tick();
      trig_req_n <= 1'b0;
      cyc(6);
      got[7] = rb_pin;
      for (int b = 6; b >= 0; b--) begin
         wait_tick();
         cyc(4);
         got[b] = rb_pin;
      end
      chk("readback", got, 32'hA5);
      trig_req_n <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h12);
      tdo_in <= 1'b1;
      cyc(4);
      chk("tdo_hi", rb_pin, 32'h1);
      tdo_in <= 1'b0;
      cyc(4);
      chk("tdo_lo", rb_pin, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h04);
      trig_req_n <= 1'b0;
      cyc(6);
      chk("ts_user", global_tristate, 32'h1);
      chk("oe_ts", user_oe, 32'h0);
      trig_req_n <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h08);
      reset_pin_in <= 1'b0;
      cyc(6);
      chk("gsr", {global_set_reset, user_reset}, 32'h3);
      reset_pin_in <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h00);
      reset_pin_in <= 1'b0;
      cyc(6);
      chk("usr_rst", {user_reset, config_active}, 32'h0);
      reset_pin_in <= 1'b1;
      cyc(4);
      conclude();
   end
endmodule : tb
`default_nettype wire
